//--- src/sfd_diag.sv
// Fault latching, sense routing and supply-loss logic of a quad switch.
`timescale 1ns/10ps
`default_nettype none
`include "sfd_params.svh"
module sfd_diag
    import sfd_pkg::*;
#(
    parameter int LED_PERIOD = `SFD_LED_PERIOD_CYC
) (
    input  wire logic           clk,
    input  wire logic           reset_n,
    input  wire sfd_cfg_t       cfg_in,
    input  wire logic           cfg_write,
    input  wire logic           status_read,
    input  wire logic           fail_safe_mode,
    input  wire logic [3:0]     out_cmd,
    input  wire logic [3:0]     direct_in,
    input  wire logic [6:0]     duty [4],
    input  wire logic [3:0]     overload_off,
    input  wire logic [3:0]     short_above_thr,
    input  wire logic [3:0]     open_above_thr,
    input  wire logic [3:0]     gate_low,
    input  wire logic [3:0]     below_bulb_thr,
    input  wire logic [3:0]     below_led_thr,
    input  wire logic           temp_above_warn,
    input  wire logic           battery_above_clamp,
    input  wire logic           battery_supply_ok,
    input  wire logic           logic_supply_ok,
    input  wire logic           logic_supply_fail,
    input  wire logic           both_supplies_por,
    output var  sfd_cfg_t       cfg,
    output var  sfd_flags_t     flags,
    output var  logic [3:0]     out_on,
    output var  logic           fault_status_pin_n,
    output var  sfd_sense_t     sense_mode,
    output var  logic [1:0]     sense_channel,
    output var  logic           sense_ratio,
    output var  logic           sense_active
);
    // Analog comparator and supply levels arrive asynchronously.
    // Supplies travel as loss levels, so the cleared synchroniser reads as
    // healthy and no false supply loss follows a reset.
    localparam int NA = 30;
    logic [NA-1:0] raw;
    logic [NA-1:0] s;

    assign raw = {short_above_thr, open_above_thr, gate_low, below_bulb_thr,
                  below_led_thr, direct_in, temp_above_warn,
                  battery_above_clamp, !battery_supply_ok, !logic_supply_ok,
                  logic_supply_fail, both_supplies_por};

    sfd_sync #(.W(NA)) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .d       (raw),
        .q       (s)
    );

    logic [3:0] short_s;
    logic [3:0] open_s;
    logic [3:0] gate_low_s;
    logic [3:0] bulb_s;
    logic [3:0] led_s;
    logic       temp_s;
    logic       clamp_s;
    logic       bat_ok_s;
    logic       vdd_ok_s;
    logic       vdd_fail_s;
    logic       por_s;
    logic [3:0] ovl_s;
    logic [3:0] dir_s;

    assign short_s    = s[29:26];
    assign open_s     = s[25:22];
    assign gate_low_s = s[21:18];
    assign bulb_s     = s[17:14];
    assign led_s      = s[13:10];
    assign dir_s      = s[9:6];
    assign temp_s     = s[5];
    assign clamp_s    = s[4];
    assign bat_ok_s   = !s[3];
    assign vdd_ok_s   = !s[2];
    assign vdd_fail_s = s[1];
    assign por_s      = s[0];

    // Overload turn-off comes from on-chip logic on this clock.
    assign ovl_s = overload_off;

    logic tick;

    sfd_tick #(.PERIOD(LED_PERIOD)) u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    // Configuration wipe on logic supply loss, power-on reset or enabled logic supply fail; not on battery loss.
    logic cfg_wipe;
    assign cfg_wipe = !vdd_ok_s || (vdd_fail_s && cfg.supply_fail_enable)
                      || por_s;

    always_ff @(posedge clk) begin
        if (!reset_n || cfg_wipe) begin
            cfg <= '0;
        end else if (cfg_write) begin
            // Held across battery loss while logic supply is good.
            cfg <= cfg_in;
        end
    end

    // Protections keep running without logic supply, on a zero config.
    sfd_cfg_t eff;
    assign eff = vdd_ok_s ? cfg : '0;

    logic [3:0] cmd_eff;
    assign cmd_eff = vdd_ok_s ? out_cmd : dir_s;

    logic [3:0] short_det;
    logic [3:0] open_det;
    logic [3:0] on_det;
    logic [3:0] led_full;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            short_det[i] = !cmd_eff[i] && short_s[i]
                           && !eff.short_detect_disable[i];
            open_det[i]  = !cmd_eff[i] && open_s[i]
                           && !eff.off_open_load_disable[i];
            led_full[i]  = duty[i] == `SFD_DUTY_FULL;
            if (eff.led_load_select[i]) begin
                on_det[i] = cmd_eff[i] && led_s[i] && led_full[i]
                            && tick;
            end else begin
                on_det[i] = cmd_eff[i] && bulb_s[i];
            end
            if (eff.on_open_load_disable[i]) begin
                on_det[i] = 1'b0;
            end
        end
    end

    // Short and off-state open load flags latch once the gate is low; on-state open load does not wait for it; the set always beats the clear.
    logic [3:0] short_live;
    logic [3:0] off_live;
    logic [3:0] on_live;
    assign short_live = short_det & gate_low_s;
    assign off_live   = (open_det | short_det) & gate_low_s;
    assign on_live    = on_det;

    logic pin_fault;

    always_ff @(posedge clk) begin
        if (!reset_n || por_s) begin
            flags <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (short_live[i]) begin
                    flags.short_to_supply_flag[i] <= 1'b1;
                end else if (status_read) begin
                    flags.short_to_supply_flag[i] <= 1'b0;
                end
                if (off_live[i]) begin
                    flags.off_open_load_flag[i] <= 1'b1;
                end else if (status_read && !pin_fault) begin
                    flags.off_open_load_flag[i] <= 1'b0;
                end
                if (on_live[i] || (cmd_eff[i] && !eff.on_open_load_disable[i]
                    && (eff.led_load_select[i] ? 1'b0 : bulb_s[i]))) begin
                    flags.on_open_load_flag[i] <= 1'b1;
                end else if (status_read) begin
                    flags.on_open_load_flag[i] <= 1'b0;
                end
            end
            if (temp_s && !fail_safe_mode) begin
                flags.temperature_prewarning_flag <= 1'b1;
            end else if (status_read) begin
                flags.temperature_prewarning_flag <= 1'b0;
            end
            if (!bat_ok_s) begin
                flags.undervoltage_flag <= 1'b1;
            end else if (status_read) begin
                flags.undervoltage_flag <= 1'b0;
            end
        end
    end

    // Pin shows off-state faults live; on-state open load leaves it alone.
    assign pin_fault = |(short_det | open_det);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fault_status_pin_n <= 1'b1;
        end else begin
            fault_status_pin_n <= !pin_fault;
        end
    end

    // Clamp overrides an overload turn-off and switches every output on.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_on <= 4'h0;
        end else if (clamp_s && |ovl_s) begin
            out_on <= 4'hf;
        end else begin
            out_on <= cmd_eff & ~ovl_s;
        end
    end

    // Sense routing: temperature wins over current copy when enabled.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sense_mode    <= SFD_SNS_OFF;
            sense_channel <= 2'h0;
            sense_ratio   <= 1'b0;
            sense_active  <= 1'b0;
        end else begin
            sense_channel <= eff.sense_channel_select;
            sense_ratio   <= eff.sense_copy_ratio[eff.sense_channel_select];
            if (eff.temp_enable) begin
                sense_mode   <= SFD_SNS_TEMP;
                sense_active <= 1'b1;
            end else if (eff.sense_route_enable && !fail_safe_mode) begin
                sense_mode   <= SFD_SNS_CURRENT;
                sense_active <= cmd_eff[eff.sense_channel_select];
            end else begin
                sense_mode   <= SFD_SNS_OFF;
                sense_active <= 1'b0;
            end
        end
    end

    property p_short_sets;
        @(posedge clk) disable iff (!reset_n)
        short_live[0] |=> flags.short_to_supply_flag[0];
    endproperty
    a_short_sets: assert property (p_short_sets)
        else $error("short flag not set");

    property p_short_off_both;
        @(posedge clk) disable iff (!reset_n)
        short_live[1] |=> flags.off_open_load_flag[1];
    endproperty
    a_short_off_both: assert property (p_short_off_both)
        else $error("off open load flag not set with short");

    property p_pin_live;
        @(posedge clk) disable iff (!reset_n)
        pin_fault |=> !fault_status_pin_n;
    endproperty
    a_pin_live: assert property (p_pin_live)
        else $error("fault pin not low on fault");

    property p_persist;
        @(posedge clk) disable iff (!reset_n || por_s)
        (status_read && short_live[0]) |=> flags.short_to_supply_flag[0];
    endproperty
    a_persist: assert property (p_persist)
        else $error("flag cleared while condition persists");

    property p_off_hold;
        @(posedge clk) disable iff (!reset_n || por_s)
        (flags.off_open_load_flag[0] && pin_fault && status_read)
            |=> flags.off_open_load_flag[0];
    endproperty
    a_off_hold: assert property (p_off_hold)
        else $error("off open load flag dropped");

    property p_clamp;
        @(posedge clk) disable iff (!reset_n)
        (clamp_s && |ovl_s) |=> out_on == 4'hf;
    endproperty
    a_clamp: assert property (p_clamp)
        else $error("clamp did not switch outputs on");

    property p_failsafe;
        @(posedge clk) disable iff (!reset_n)
        fail_safe_mode |=> sense_mode != SFD_SNS_CURRENT;
    endproperty
    a_failsafe: assert property (p_failsafe)
        else $error("current copy active in fail safe");

    property p_wipe;
        @(posedge clk) disable iff (!reset_n)
        cfg_wipe |=> cfg == '0;
    endproperty
    a_wipe: assert property (p_wipe)
        else $error("configuration not wiped");

    property p_uv;
        @(posedge clk) disable iff (!reset_n || por_s)
        !bat_ok_s |=> flags.undervoltage_flag;
    endproperty
    a_uv: assert property (p_uv)
        else $error("undervoltage flag not set");
endmodule // sfd_diag
`default_nettype wire

//--- pkg/sfd_params.svh
// Timing counts and field constants for the switch fault diagnostics block.
`ifndef SFD_PARAMS_SVH
`define SFD_PARAMS_SVH
`define SFD_NUM_CH          4
`define SFD_DUTY_W          7
`define SFD_DUTY_FULL       7'h7f
`define SFD_CLK_MHZ         100
`define SFD_LED_PERIOD_US   1000
`define SFD_LED_PERIOD_CYC  (`SFD_LED_PERIOD_US * `SFD_CLK_MHZ)
`endif

//--- pkg/sfd_pkg.sv
// Types shared by the switch fault diagnostics block.
package sfd_pkg;
    typedef struct packed {
        logic [3:0] short_detect_disable;
        logic [3:0] off_open_load_disable;
        logic [3:0] on_open_load_disable;
        logic [3:0] led_load_select;
        logic [3:0] sense_copy_ratio;
        logic       temp_enable;
        logic       sense_route_enable;
        logic [1:0] sense_channel_select;
        logic       supply_fail_enable;
    } sfd_cfg_t;

    typedef struct packed {
        logic [3:0] short_to_supply_flag;
        logic [3:0] off_open_load_flag;
        logic [3:0] on_open_load_flag;
        logic       temperature_prewarning_flag;
        logic       undervoltage_flag;
    } sfd_flags_t;

    typedef enum logic [1:0] {
        SFD_SNS_OFF,
        SFD_SNS_CURRENT,
        SFD_SNS_TEMP
    } sfd_sense_t;
endpackage

//--- src/sfd_sync.sv
// Two-stage synchroniser for a bus of asynchronous levels.
`timescale 1ns/10ps
`default_nettype none
module sfd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // sfd_sync
`default_nettype wire

//--- src/sfd_tick.sv
// Divider that pulses once per LED open-load check period.
`timescale 1ns/10ps
`default_nettype none
module sfd_tick #(
    parameter int PERIOD = 100000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    output var  logic tick
);
    logic [31:0] cnt;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt  <= 32'h0;
            tick <= 1'b0;
        end else if (cnt == 32'(PERIOD - 1)) begin
            cnt  <= 32'h0;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 32'h1;
            tick <= 1'b0;
        end
    end
endmodule // sfd_tick
`default_nettype wire

//--- dv/sfd_host_model.sv
// Host model that writes the configuration word and reads status.
`timescale 1ns/10ps
`default_nettype none
module sfd_host_model
    import sfd_pkg::*;
(
    input  wire logic     clk,
    output var  sfd_cfg_t cfg_in,
    output var  logic     cfg_write,
    output var  logic     status_read
);
    initial begin
        cfg_in = '0;
        cfg_write = 1'b0;
        status_read = 1'b0;
    end
    // Strobes last exactly one edge so the block takes each request once.
    task automatic write_cfg(input sfd_cfg_t c);
        @(posedge clk);
        #1;
        cfg_in = c;
        cfg_write = 1'b1;
        @(posedge clk);
        #1;
        cfg_write = 1'b0;
    endtask
    task automatic read_status();
        @(posedge clk);
        #1;
        status_read = 1'b1;
        @(posedge clk);
        #1;
        status_read = 1'b0;
    endtask
endmodule // sfd_host_model
`default_nettype wire

//--- dv/test_switch_fault_diagnostics.sv
// Self-checking bench for the switch fault diagnostics block.
`timescale 1ns/10ps
`default_nettype none
module test_switch_fault_diagnostics;
    import sfd_pkg::*;
    localparam int LP = 16;
    typedef struct {int sel; logic [31:0] exp;} sfd_note_t;
    logic       clk, reset_n, fail_safe_mode, temp_above_warn;
    logic       battery_above_clamp, battery_supply_ok, logic_supply_ok;
    logic       logic_supply_fail, both_supplies_por;
    logic [3:0] out_cmd, direct_in, overload_off, short_above_thr;
    logic [3:0] open_above_thr, gate_low, below_bulb_thr, below_led_thr;
    logic [6:0] duty [4];
    logic       cfg_write, status_read, fault_status_pin_n;
    logic       sense_ratio, sense_active;
    logic [3:0] out_on;
    logic [1:0] sense_channel;
    sfd_cfg_t   cfg_in, cfg, c;
    sfd_flags_t flags, f;
    sfd_sense_t sense_mode;
    int         fail_count, tests_run;
    logic [31:0] lfsr;
    sfd_note_t  notes[$];
    event       look;
    string      names[7] = '{"flags", "pin", "out_on", "cfg", "sense_mode",
                             "sense_active", "sense_route"};

    sfd_host_model sfd_host_model_i (.clk, .cfg_in, .cfg_write, .status_read);
    sfd_diag #(.LED_PERIOD(LP)) sfd_diag_i (.clk, .reset_n, .cfg_in,
        .cfg_write, .status_read, .fail_safe_mode, .out_cmd, .direct_in,
        .duty, .overload_off, .short_above_thr, .open_above_thr, .gate_low,
        .below_bulb_thr, .below_led_thr, .temp_above_warn,
        .battery_above_clamp, .battery_supply_ok, .logic_supply_ok,
        .logic_supply_fail, .both_supplies_por, .cfg, .flags, .out_on,
        .fault_status_pin_n, .sense_mode, .sense_channel, .sense_ratio,
        .sense_active);

    function automatic logic [31:0] seen(input int sel);
        case (sel)
            0: return {18'h0, flags};
            1: return {31'h0, fault_status_pin_n};
            2: return {28'h0, out_on};
            3: return {7'h0, cfg};
            4: return {30'h0, sense_mode};
            5: return {31'h0, sense_active};
            default: return {29'h0, sense_channel, sense_ratio};
        endcase
    endfunction
    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Draining the whole queue keeps notes posted in one time step safe.
    always @(look) begin
        while (notes.size() > 0) begin
            sfd_note_t n;
            n = notes.pop_front();
            tests_run++;
            if (seen(n.sel) !== n.exp) begin
                fail_count++;
                $display("ERROR %s expected %h seen %h", names[n.sel], n.exp,
                         seen(n.sel));
            end
        end
    end

    task automatic chk(input int sel, input logic [31:0] exp);
        notes.push_back('{sel, exp});
        -> look;
    endtask
    task automatic chkf(input sfd_flags_t e);
        chk(0, {18'h0, e});
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rd();
        sfd_host_model_i.read_status();
        step(1);
    endtask
    task automatic wr(input sfd_cfg_t v);
        sfd_host_model_i.write_cfg(v);
        step(1);
    endtask
    task automatic finish_test();
        #1;
        if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wait_led(input int ch);
        int i;
        for (i = 0; i < 4 * LP; i++) begin
            if (flags.on_open_load_flag[ch] === 1'b1) break;
            step(1);
        end
        if (i == 4 * LP) begin
            fail_count++;
            finish_test();
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        {reset_n, fail_safe_mode, temp_above_warn, battery_above_clamp} = '0;
        {out_cmd, direct_in, overload_off, short_above_thr} = '0;
        {open_above_thr, below_bulb_thr, below_led_thr} = '0;
        {logic_supply_fail, both_supplies_por} = '0;
        {battery_supply_ok, logic_supply_ok} = 2'h3;
        gate_low = 4'hf;
        duty = '{default: 7'h7f};
        {fail_count, tests_run} = '0;
        lfsr = 32'h00016a62;
        step(8);
        reset_n = 1'b1;
        step(3);
        chk(1, 32'h1);
        short_above_thr = 4'h1;
        step(4);
        f = '0;
        f.short_to_supply_flag = 4'h1;
        f.off_open_load_flag = 4'h1;
        chkf(f);
        chk(1, 32'h0);
        rd();
        chkf(f);
        short_above_thr = 4'h0;
        step(4);
        chk(1, 32'h1);
        chkf(f);
        rd();
        chkf('0);
        open_above_thr = 4'h2;
        step(4);
        f = '0;
        f.off_open_load_flag = 4'h2;
        chkf(f);
        open_above_thr = 4'h0;
        step(4);
        rd();
        chkf('0);
        c = '0;
        c.short_detect_disable = 4'h1;
        c.off_open_load_disable = 4'h2;
        wr(c);
        {short_above_thr, open_above_thr} = 8'h12;
        step(4);
        chkf('0);
        {short_above_thr, open_above_thr} = 8'h0;
        c = '0;
        c.led_load_select = 4'h8;
        wr(c);
        // Outputs stay commanded on well past one check period.
        out_cmd = 4'hc;
        below_bulb_thr = 4'h4;
        below_led_thr = 4'h8;
        wait_led(3);
        step(4);
        f = '0;
        f.on_open_load_flag = 4'hc;
        chkf(f);
        chk(2, 32'hc);
        chk(1, 32'h1);
        {below_bulb_thr, below_led_thr} = 8'h0;
        step(4);
        chkf(f);
        rd();
        chkf('0);
        // A channel below full duty must not be checked for LED open load.
        duty[3] = 7'h3f;
        below_led_thr = 4'h8;
        step(4 * LP);
        chkf('0);
        duty[3] = 7'h7f;
        c.on_open_load_disable = 4'hc;
        wr(c);
        {below_bulb_thr, below_led_thr} = 8'h48;
        step(4 * LP);
        chkf('0);
        {below_bulb_thr, below_led_thr} = 8'h0;
        c = '0;
        c.sense_route_enable = 1'b1;
        c.sense_channel_select = 2'h2;
        wr(c);
        step(3);
        chk(4, {30'h0, SFD_SNS_CURRENT});
        chk(6, {29'h0, 2'h2, 1'b0});
        chk(5, 32'h1);
        out_cmd = 4'h8;
        step(4);
        chk(5, 32'h0);
        out_cmd = 4'h4;
        fail_safe_mode = 1'b1;
        step(4);
        chk(5, 32'h0);
        fail_safe_mode = 1'b0;
        c.temp_enable = 1'b1;
        wr(c);
        step(3);
        chk(4, {30'h0, SFD_SNS_TEMP});
        temp_above_warn = 1'b1;
        step(4);
        temp_above_warn = 1'b0;
        step(4);
        f = '0;
        f.temperature_prewarning_flag = 1'b1;
        chkf(f);
        rd();
        chkf('0);
        out_cmd = 4'h0;
        {overload_off, battery_above_clamp} = 5'h3;
        step(4);
        chk(2, 32'hf);
        {overload_off, battery_above_clamp} = 5'h0;
        battery_supply_ok = 1'b0;
        step(4);
        f = '0;
        f.undervoltage_flag = 1'b1;
        chkf(f);
        chk(3, {7'h0, c});
        c.sense_copy_ratio = 4'h5;
        wr(c);
        chk(3, {7'h0, c});
        chk(6, {29'h0, 2'h2, 1'b1});
        battery_supply_ok = 1'b1;
        step(4);
        rd();
        c.supply_fail_enable = 1'b1;
        wr(c);
        logic_supply_fail = 1'b1;
        step(4);
        chk(3, 32'h0);
        logic_supply_fail = 1'b0;
        logic_supply_ok = 1'b0;
        for (int k = 0; k < 4; k++) begin
            lfsr = next_lfsr(lfsr);
            direct_in = lfsr[3:0];
            step(4);
            chk(2, {28'h0, direct_in});
        end
        direct_in = 4'h0;
        short_above_thr = 4'h2;
        step(4);
        f = '0;
        f.short_to_supply_flag = 4'h2;
        f.off_open_load_flag = 4'h2;
        chkf(f);
        chk(3, 32'h0);
        short_above_thr = 4'h0;
        logic_supply_ok = 1'b1;
        step(4);
        wr(c);
        both_supplies_por = 1'b1;
        step(4);
        chk(3, 32'h0);
        chkf('0);
        both_supplies_por = 1'b0;
        step(4);
        finish_test();
    end
endmodule // test_switch_fault_diagnostics
`default_nettype wire
